// >>> dv/host_model.sv
// Host processor model that issues commands on the parallel host port.
module host_model (
  // Clock
  input wire logic clock,
  // Command toward the device
  output usb_irq_pkg::host_cmd_t host_cmd
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Command issue
  initial host_cmd = '0;

  // One command per call. Once released, code and data are inverted so a stale word never looks live.
  task automatic access(input logic [7:0] code, input logic [31:0] data);
    @(posedge clock);
    #1;
    host_cmd = {1'b1, code, data};
    @(posedge clock);
    #1;
    host_cmd = {1'b0, ~code, ~data};
  endtask
endmodule

// >>> dv/usb_host_interrupt_logic_bench.sv
// Self-checking bench of the USB host interrupt logic.
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("unexpected at %0t got %h expected %h", $time, a, e); end end

module usb_host_interrupt_logic_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals and bookkeeping
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic clock_enable = 1'b1;
  usb_irq_pkg::host_cmd_t host_cmd;
  usb_irq_pkg::event_in_t events = '0;
  logic [31:0] read_data_q;
  logic read_valid_q;
  logic interrupt_request_q;
  logic sof_token_q;
  logic halt_processing_q;
  logic [1:0] overrun_count_q;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int overruns = 0;
  int srcs[6] = '{0, 2, 3, 4, 5, 6};
  logic [31:0] rnd;
  logic [31:0] expected;
  logic [31:0] exp_q[$];

  always #4 clock = ~clock;

  host_model host (.clock(clock), .host_cmd(host_cmd));

  usb_host_interrupt_logic DUT (
    .clock(clock), .reset(reset), .clock_enable(clock_enable), .host_cmd(host_cmd),
    .events(events), .read_data_q(read_data_q), .read_valid_q(read_valid_q),
    .interrupt_request_q(interrupt_request_q), .sof_token_q(sof_token_q),
    .halt_processing_q(halt_processing_q), .overrun_count_q(overrun_count_q)
  );

  // ==========================================================================
  // Tasks
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic rd(input logic [7:0] c, input logic [31:0] e);
    exp_q.push_back(e);
    host.access(c, $urandom);
  endtask

  // Raises one event source for a single clock edge.
  task automatic fire(input int b);
    @(posedge clock);
    #1;
    case (b)
      0: events.schedule_overrun = 1'b1;
      2: events.frame_start = 1'b1;
      3: events.resume_signal = 1'b1;
      4: events.system_error = 1'b1;
      5: events.frame_number[15] = ~events.frame_number[15];
      default: events.port2_status = events.port2_status ^ ($urandom | 32'h1);
    endcase
    step(1);
    events.schedule_overrun = 1'b0;
    events.frame_start = 1'b0;
    events.resume_signal = 1'b0;
    events.system_error = 1'b0;
  endtask

  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Read answers are matched against the oldest expectation.
  always @(negedge clock) begin
    if (read_valid_q === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("unexpected at %0t got %h expected %h", $time, read_valid_q, 1'b0);
      end else begin
        expected = exp_q.pop_front();
        `CHK(read_data_q, expected)
      end
    end
  end

  // The whole sequence needs about 130 cycles; this ceiling only cuts a hang.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      conclude();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(87));
    step(10);
    reset = 1'b0;
    step(1);
    `CHK(interrupt_request_q, 1'b0)
    `CHK(overrun_count_q, 2'h0)
    rd(usb_irq_pkg::CMD_RD_ENABLE, 32'h0);
    rd(usb_irq_pkg::CMD_RD_FLAGS, 32'h0);
    foreach (srcs[i]) begin
      fire(srcs[i]);
      `CHK(sof_token_q, 1'(srcs[i] == 2))
      `CHK(halt_processing_q, 1'(srcs[i] == 4))
      overruns += int'(srcs[i] == 0);
      rd(usb_irq_pkg::CMD_RD_FLAGS, 32'h1 << srcs[i]);
      host.access(usb_irq_pkg::CMD_WR_FLAGS, 32'h1 << srcs[i]);
      rd(usb_irq_pkg::CMD_RD_FLAGS, 32'h0);
      `CHK(halt_processing_q, 1'b0)
      `CHK(interrupt_request_q, 1'b0)
    end
    events.sw_resume_state = 1'b1;
    fire(3);
    events.sw_resume_state = 1'b0;
    rd(usb_irq_pkg::CMD_RD_FLAGS, 32'h0);
    events.schedule_overrun = 1'b1;
    step(5);
    events.schedule_overrun = 1'b0;
    overruns += 5;
    step(1);
    `CHK(overrun_count_q, 2'(overruns))
    clock_enable = 1'b0;
    fire(0);
    clock_enable = 1'b1;
    `CHK(overrun_count_q, 2'(overruns))
    host.access(usb_irq_pkg::CMD_WR_FLAGS, 32'h1);
    host.access(usb_irq_pkg::CMD_WR_ENABLE, 32'h5);
    host.access(usb_irq_pkg::CMD_WR_ENABLE, 32'h40);
    host.access(usb_irq_pkg::CMD_WR_ENABLE, 32'h7FFFFF82);
    rd(usb_irq_pkg::CMD_RD_ENABLE, 32'h45);
    host.access(usb_irq_pkg::CMD_WR_ENABLE, 32'h0);
    rd(usb_irq_pkg::CMD_RD_DISABLE, 32'h45);
    fire(2);
    step(2);
    `CHK(interrupt_request_q, 1'b0)
    host.access(usb_irq_pkg::CMD_WR_ENABLE, 32'h80000000);
    step(1);
    `CHK(interrupt_request_q, 1'b1)
    host.access(usb_irq_pkg::CMD_WR_ENABLE, 32'h0);
    step(1);
    `CHK(interrupt_request_q, 1'b1)
    host.access(usb_irq_pkg::CMD_WR_FLAGS, 32'h4);
    step(1);
    `CHK(interrupt_request_q, 1'b0)
    fire(6);
    step(1);
    `CHK(interrupt_request_q, 1'b1)
    host.access(usb_irq_pkg::CMD_WR_DISABLE, 32'h80000000);
    step(1);
    `CHK(interrupt_request_q, 1'b0)
    rnd = $urandom;
    host.access(usb_irq_pkg::CMD_WR_DISABLE, rnd);
    rd(usb_irq_pkg::CMD_RD_ENABLE, 32'h45 & ~rnd);
    host.access(usb_irq_pkg::CMD_WR_FLAGS, 32'hFFFFFFFF);
    host.access(usb_irq_pkg::CMD_WR_FLAGS, 32'hFFFFFFFF);
    rd(usb_irq_pkg::CMD_RD_FLAGS, 32'h0);
    reset = 1'b1;
    step(1);
    reset = 1'b0;
    step(1);
    `CHK(overrun_count_q, 2'h0)
    rd(usb_irq_pkg::CMD_RD_FLAGS, 32'h0);
    rd(usb_irq_pkg::CMD_RD_ENABLE, 32'h0);
    step(3);
    `CHK(exp_q.size(), 0)
    conclude();
  end
endmodule

// >>> hdl/change_detect.sv
// Flags a change of a watched value against its registered copy.
module change_detect #(
  parameter int unsigned WIDTH = 32
) (
  // Clock and control
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  // Watched value and result
  input wire logic [WIDTH-1:0] value,
  output logic changed
);

  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] prev_d;
  logic primed_q;
  logic primed_d;

  // The first sample after reset only primes the copy, so a nonzero
  // value at power up is not mistaken for a change.
  always_comb begin
    prev_d = value;
    primed_d = 1'b1;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      prev_q <= '0;
      primed_q <= 1'b0;
    end else if (clock_enable) begin
      prev_q <= prev_d;
      primed_q <= primed_d;
    end
  end

  assign changed = primed_q && (value != prev_q);

endmodule

// >>> hdl/sticky_flag.sv
// One sticky event flag: hardware sets, software clears by writing one.
module sticky_flag (
  // Clock and control
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  // Set and clear requests
  input wire logic set,
  input wire logic clear,
  output logic flag
);

  logic flag_q;
  logic flag_d;

  // Set wins over clear so an event in the clearing cycle is not lost.
  always_comb begin
    flag_d = flag_q;
    if (set) begin
      flag_d = 1'b1;
    end else if (clear) begin
      flag_d = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else if (clock_enable) begin
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;

endmodule

// >>> hdl/usb_host_interrupt_logic.sv
// Interrupt event flags, enables and request output of the USB host controller.
module usb_host_interrupt_logic (
  // Clock and control
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  // Host port command
  input wire usb_irq_pkg::host_cmd_t host_cmd,
  // Event sources
  input wire usb_irq_pkg::event_in_t events,
  // Host port read answer
  output logic [usb_irq_pkg::DATA_W-1:0] read_data_q,
  output logic read_valid_q,
  // Status toward the rest of the controller
  output logic interrupt_request_q,
  output logic sof_token_q,
  output logic halt_processing_q,
  output logic [usb_irq_pkg::COUNT_W-1:0] overrun_count_q
);

  // ===========================================================================
  // Event detection
  logic root_hub_changed;
  logic port1_changed;
  logic port2_changed;
  logic frame_msb_changed;
  logic resume_prev_q;
  logic resume_prev_d;
  logic resume_edge;
  logic [usb_irq_pkg::DATA_W-1:0] set_vec;
  logic [usb_irq_pkg::DATA_W-1:0] clear_vec;
  logic [usb_irq_pkg::DATA_W-1:0] flags;

  change_detect #(.WIDTH(usb_irq_pkg::DATA_W)) root_hub_watch (
    .clock(clock),
    .reset(reset),
    .clock_enable(clock_enable),
    .value(events.root_hub_status),
    .changed(root_hub_changed)
  );

  change_detect #(.WIDTH(usb_irq_pkg::DATA_W)) port1_watch (
    .clock(clock),
    .reset(reset),
    .clock_enable(clock_enable),
    .value(events.port1_status),
    .changed(port1_changed)
  );

  change_detect #(.WIDTH(usb_irq_pkg::DATA_W)) port2_watch (
    .clock(clock),
    .reset(reset),
    .clock_enable(clock_enable),
    .value(events.port2_status),
    .changed(port2_changed)
  );

  // Only the top bit is watched; it toggles once per counter half-wrap.
  change_detect #(.WIDTH(1)) frame_msb_watch (
    .clock(clock),
    .reset(reset),
    .clock_enable(clock_enable),
    .value(events.frame_number[usb_irq_pkg::FRAME_MSB]),
    .changed(frame_msb_changed)
  );

  // A resume edge while software itself drives the resume state is not
  // a device wakeup and must not raise the flag.
  assign resume_edge = events.resume_signal && !resume_prev_q && !events.sw_resume_state;

  // ===========================================================================
  // Command decode
  logic wr_flags;
  logic wr_enable;
  logic wr_disable;
  logic rd_flags;
  logic rd_enable;

  assign wr_flags = host_cmd.valid && (host_cmd.code == usb_irq_pkg::CMD_WR_FLAGS);
  assign rd_flags = host_cmd.valid && (host_cmd.code == usb_irq_pkg::CMD_RD_FLAGS);
  assign wr_enable = host_cmd.valid && (host_cmd.code == usb_irq_pkg::CMD_WR_ENABLE);
  assign wr_disable = host_cmd.valid && (host_cmd.code == usb_irq_pkg::CMD_WR_DISABLE);
  assign rd_enable = host_cmd.valid &&
    ((host_cmd.code == usb_irq_pkg::CMD_RD_ENABLE) || (host_cmd.code == usb_irq_pkg::CMD_RD_DISABLE));

  // ===========================================================================
  // Event flags
  always_comb begin
    set_vec = usb_irq_pkg::WORD_ZERO;
    set_vec[usb_irq_pkg::BIT_ROOT_HUB] = root_hub_changed || port1_changed || port2_changed;
    set_vec[usb_irq_pkg::BIT_FRAME_OVERFLOW] = frame_msb_changed;
    set_vec[usb_irq_pkg::BIT_FATAL] = events.system_error;
    set_vec[usb_irq_pkg::BIT_RESUME] = resume_edge;
    set_vec[usb_irq_pkg::BIT_FRAME_START] = events.frame_start;
    set_vec[usb_irq_pkg::BIT_SCHED_OVERRUN] = events.schedule_overrun;
    clear_vec = usb_irq_pkg::WORD_ZERO;
    if (wr_flags) begin
      clear_vec = host_cmd.data & usb_irq_pkg::EVENT_MASK;
    end
  end

  // Reserved positions have no storage and read as zero.
  for (genvar i = 0; i < usb_irq_pkg::DATA_W; i++) begin : g_flag
    if (usb_irq_pkg::EVENT_MASK[i]) begin : g_used
      sticky_flag flag_bit (
        .clock(clock),
        .reset(reset),
        .clock_enable(clock_enable),
        .set(set_vec[i]),
        .clear(clear_vec[i]),
        .flag(flags[i])
      );
    end else begin : g_reserved
      assign flags[i] = 1'b0;
    end
  end

  // ===========================================================================
  // Enables, counter and outputs
  logic [usb_irq_pkg::DATA_W-1:0] enable_q;
  logic [usb_irq_pkg::DATA_W-1:0] enable_d;
  logic [usb_irq_pkg::COUNT_W-1:0] overrun_count_d;
  logic [usb_irq_pkg::DATA_W-1:0] read_data_d;
  logic read_valid_d;
  logic interrupt_request_d;
  logic sof_token_d;
  logic halt_processing_d;

  always_comb begin
    enable_d = enable_q;
    if (wr_enable) begin
      enable_d = enable_q | (host_cmd.data & usb_irq_pkg::ENABLE_MASK);
    end else if (wr_disable) begin
      enable_d = enable_q & ~(host_cmd.data & usb_irq_pkg::ENABLE_MASK);
    end
    overrun_count_d = overrun_count_q;
    if (events.schedule_overrun) begin
      overrun_count_d = overrun_count_q + usb_irq_pkg::COUNT_STEP;
    end
    read_valid_d = rd_flags || rd_enable;
    read_data_d = read_data_q;
    if (rd_flags) begin
      read_data_d = flags;
    end else if (rd_enable) begin
      read_data_d = enable_q;
    end
    interrupt_request_d = enable_q[usb_irq_pkg::BIT_MASTER] &&
      (|(flags & enable_q & usb_irq_pkg::EVENT_MASK));
    sof_token_d = events.frame_start;
    // The halt holds while the error persists and until software clears
    // the flag, which it does only after resetting the controller.
    halt_processing_d = events.system_error || flags[usb_irq_pkg::BIT_FATAL];
    resume_prev_d = events.resume_signal;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      enable_q <= usb_irq_pkg::ENABLE_RESET;
      overrun_count_q <= usb_irq_pkg::COUNT_RESET;
      read_data_q <= usb_irq_pkg::WORD_ZERO;
      read_valid_q <= 1'b0;
      interrupt_request_q <= 1'b0;
      sof_token_q <= 1'b0;
      halt_processing_q <= 1'b0;
      resume_prev_q <= 1'b0;
    end else if (clock_enable) begin
      enable_q <= enable_d;
      overrun_count_q <= overrun_count_d;
      read_data_q <= read_data_d;
      read_valid_q <= read_valid_d;
      interrupt_request_q <= interrupt_request_d;
      sof_token_q <= sof_token_d;
      halt_processing_q <= halt_processing_d;
      resume_prev_q <= resume_prev_d;
    end
  end

  // ===========================================================================
  // Assertions
  sequence flag_live_s;
    clock_enable && enable_q[usb_irq_pkg::BIT_MASTER] && (|(flags & enable_q & usb_irq_pkg::EVENT_MASK));
  endsequence

  sequence master_off_s;
    clock_enable && !enable_q[usb_irq_pkg::BIT_MASTER];
  endsequence

  sequence source_idle_s;
    clock_enable && !(|(flags & enable_q & usb_irq_pkg::EVENT_MASK));
  endsequence

  root_hub_set_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && (root_hub_changed || port1_changed || port2_changed) |=> flags[usb_irq_pkg::BIT_ROOT_HUB])
    else $error("Root hub change did not set its flag.");

  frame_overflow_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && frame_msb_changed |=> flags[usb_irq_pkg::BIT_FRAME_OVERFLOW])
    else $error("Frame counter top bit toggle did not set its flag.");

  fatal_halt_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && events.system_error |=> flags[usb_irq_pkg::BIT_FATAL] && halt_processing_q)
    else $error("System error did not set the flag and halt.");

  resume_set_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && events.resume_signal && !resume_prev_q && !events.sw_resume_state
    |=> flags[usb_irq_pkg::BIT_RESUME])
    else $error("Resume signalling did not set its flag.");

  resume_guard_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !flags[usb_irq_pkg::BIT_RESUME] && events.sw_resume_state
    |=> !flags[usb_irq_pkg::BIT_RESUME])
    else $error("Software resume entry raised the resume flag.");

  frame_start_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && events.frame_start |=> flags[usb_irq_pkg::BIT_FRAME_START] && sof_token_q)
    else $error("Frame start did not set flag and token.");

  overrun_count_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && events.schedule_overrun
    |=> flags[usb_irq_pkg::BIT_SCHED_OVERRUN] &&
      (overrun_count_q == $past(overrun_count_q) + usb_irq_pkg::COUNT_STEP))
    else $error("Overrun did not set flag and step the counter.");

  irq_raise_a: assert property (@(posedge clock) disable iff (reset)
    flag_live_s |=> interrupt_request_q)
    else $error("Enabled flag with master enable gave no request.");

  irq_gate_a: assert property (@(posedge clock) disable iff (reset)
    master_off_s |=> !interrupt_request_q)
    else $error("Request raised without master enable.");

  enable_w1s_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && wr_enable |=> ((enable_q & $past(enable_q)) == $past(enable_q)))
    else $error("Enable write cleared a bit.");

  flag_clear_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && wr_flags && host_cmd.data[usb_irq_pkg::BIT_FRAME_START] && !events.frame_start
    |=> !flags[usb_irq_pkg::BIT_FRAME_START])
    else $error("Write of one did not clear the flag.");

  enable_read_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && rd_enable |=> read_valid_q && (read_data_q == $past(enable_q)))
    else $error("Enable read returned wrong data.");

  irq_drop_a: assert property (@(posedge clock) disable iff (reset)
    source_idle_s |=> !interrupt_request_q)
    else $error("Request stayed up with no enabled flag.");

  // ===========================================================================
  // Register port and freeze guards
  flag_read_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && rd_flags |=> read_valid_q && (read_data_q == $past(flags)))
    else $error("Flag read returned wrong data.");

  idle_read_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !rd_flags && !rd_enable |=> !read_valid_q)
    else $error("Read answer without a read command.");

  enable_set_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && wr_enable
    |=> ((enable_q & $past(host_cmd.data) & usb_irq_pkg::ENABLE_MASK) ==
      ($past(host_cmd.data) & usb_irq_pkg::ENABLE_MASK)))
    else $error("Enable write did not set its ones.");

  master_keep_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && wr_enable && enable_q[usb_irq_pkg::BIT_MASTER] |=> enable_q[usb_irq_pkg::BIT_MASTER])
    else $error("Enable write cleared the master enable.");

  disable_clear_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && wr_disable
    |=> ((enable_q & $past(host_cmd.data) & usb_irq_pkg::ENABLE_MASK) == usb_irq_pkg::WORD_ZERO))
    else $error("Disable write left an enable set.");

  enable_reserved_a: assert property (@(posedge clock) disable iff (reset)
    (enable_q & ~usb_irq_pkg::ENABLE_MASK) == usb_irq_pkg::WORD_ZERO)
    else $error("Reserved enable bit holds a one.");

  flag_reserved_a: assert property (@(posedge clock) disable iff (reset)
    (flags & ~usb_irq_pkg::EVENT_MASK) == usb_irq_pkg::WORD_ZERO)
    else $error("Reserved flag bit holds a one.");

  flag_hold_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !wr_flags |=> ((flags & $past(flags)) == $past(flags)))
    else $error("Hardware cleared an event flag.");

  // Flags rise only through set_vec, never through a host write.
  flag_noset_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && (set_vec == usb_irq_pkg::WORD_ZERO)
    |=> ((flags & ~$past(flags)) == usb_irq_pkg::WORD_ZERO))
    else $error("Flag rose without an event.");

  count_hold_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !events.schedule_overrun |=> $stable(overrun_count_q))
    else $error("Overrun counter moved without an overrun.");

  halt_hold_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && flags[usb_irq_pkg::BIT_FATAL] |=> halt_processing_q)
    else $error("Halt dropped while the fatal flag stands.");

  sof_only_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !events.frame_start |=> !sof_token_q)
    else $error("Token request without a frame start.");

  // Clock enable low must freeze the enables, the sticky flags and the overrun counter.
  freeze_a: assert property (@(posedge clock) disable iff (reset)
    !clock_enable |=> $stable(enable_q) && $stable(flags) && $stable(overrun_count_q))
    else $error("State moved while the clock enable was low.");

endmodule

// >>> hdl/usb_irq_pkg.sv
// Constants, command codes and carrier types of the USB host interrupt logic.
package usb_irq_pkg;

  // ===========================================================================
  // Widths and bit positions
  localparam int unsigned DATA_W = 32;
  localparam int unsigned FRAME_W = 16;
  localparam int unsigned FRAME_MSB = 15;
  localparam int unsigned COUNT_W = 2;
  localparam int unsigned BIT_SCHED_OVERRUN = 0;
  localparam int unsigned BIT_FRAME_START = 2;
  localparam int unsigned BIT_RESUME = 3;
  localparam int unsigned BIT_FATAL = 4;
  localparam int unsigned BIT_FRAME_OVERFLOW = 5;
  localparam int unsigned BIT_ROOT_HUB = 6;
  localparam int unsigned BIT_MASTER = 31;

  // ===========================================================================
  // Masks and reset values
  localparam logic [DATA_W-1:0] EVENT_MASK = 32'h0000007D;
  localparam logic [DATA_W-1:0] ENABLE_MASK = 32'h8000007D;
  localparam logic [DATA_W-1:0] ENABLE_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 2'h0;
  localparam logic [COUNT_W-1:0] COUNT_STEP = 2'h1;

  // ===========================================================================
  // Host port command codes
  localparam logic [7:0] CMD_RD_FLAGS = 8'h03;
  localparam logic [7:0] CMD_WR_FLAGS = 8'h83;
  localparam logic [7:0] CMD_RD_ENABLE = 8'h04;
  localparam logic [7:0] CMD_WR_ENABLE = 8'h84;
  localparam logic [7:0] CMD_RD_DISABLE = 8'h05;
  localparam logic [7:0] CMD_WR_DISABLE = 8'h85;

  // ===========================================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [DATA_W-1:0] data;
  } host_cmd_t;

  typedef struct packed {
    logic [DATA_W-1:0] root_hub_status;
    logic [DATA_W-1:0] port1_status;
    logic [DATA_W-1:0] port2_status;
    logic [FRAME_W-1:0] frame_number;
    logic system_error;
    logic resume_signal;
    logic sw_resume_state;
    logic frame_start;
    logic schedule_overrun;
  } event_in_t;

endpackage
